// ---- core/stw_interval.sv ----
// Reloading 7-bit interval counter with sticky, read-cleared flag.
`timescale 1ns/100ps
`default_nettype none
module stw_interval (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Time base
    input  wire logic run,
    input  wire logic tick,
    // Register access
    stw_ivl_if.cnt    bus
);
    logic [6:0] reload_ff;
    logic [6:0] nxt_reload;
    logic [6:0] cnt_ff;
    logic [6:0] nxt_cnt;
    logic       flag_ff;
    logic       nxt_flag;
    logic       fire;

    assign fire = run && tick && cnt_ff == '0;

    always_comb
    begin
        nxt_reload = reload_ff;
        nxt_cnt    = cnt_ff;
        if (bus.wr)
        begin
            nxt_reload = bus.wdata[6:0];
        end
        if (fire)
        begin
            nxt_cnt = nxt_reload;
        end
        else if (run && tick)
        begin
            nxt_cnt = cnt_ff - 1'b1;
        end
        if (bus.wr && bus.wdata[stw_pkg::WRT_BIT])
        begin
            nxt_cnt = bus.wdata[6:0];
        end
        // A terminal count in the clearing cycle still sets the flag.
        nxt_flag = fire || (flag_ff && !bus.rd);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reload_ff <= stw_pkg::RST_INTERVAL;
            cnt_ff    <= stw_pkg::RST_INTERVAL;
            flag_ff   <= 1'b0;
        end
        else
        begin
            reload_ff <= nxt_reload;
            cnt_ff    <= nxt_cnt;
            flag_ff   <= nxt_flag;
        end
    end

    assign bus.flag   = flag_ff;
    assign bus.reload = reload_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    flag_set_a: assert property (
        fire |=> flag_ff)
        else $error("Terminal count did not set the flag.");
    read_clear_a: assert property (
        (bus.rd && !fire) |=> !flag_ff)
        else $error("Read did not clear the flag.");
    imm_load_a: assert property (
        (bus.wr && bus.wdata[stw_pkg::WRT_BIT])
        |=> cnt_ff == $past(bus.wdata[6:0]))
        else $error("Immediate write did not load the count.");
    defer_load_a: assert property (
        (bus.wr && !bus.wdata[stw_pkg::WRT_BIT] && !(run && tick))
        |=> (cnt_ff == $past(cnt_ff) && reload_ff == $past(bus.wdata[6:0])))
        else $error("Deferred write disturbed the running count.");
endmodule // stw_interval
`default_nettype wire

// ---- core/stw_ivl_if.sv ----
// Access path between the register decode and one interval counter.
`timescale 1ns/100ps
`default_nettype none
interface stw_ivl_if;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
    logic       flag;
    logic [6:0] reload;

    modport ctl (output wr, output rd, output wdata,
                 input flag, input reload);
    modport cnt (input wr, input rd, input wdata,
                 output flag, output reload);
endinterface
`default_nettype wire

// ---- core/stw_pkg.sv ----
// Shared constants and decode helper for the system tick and watchdog block.
package stw_pkg;

    // Register offsets on the special function register port.
    localparam logic [7:0] ADDR_LONG     = 8'hF9;
    localparam logic [7:0] ADDR_SHORT    = 8'hFA;
    localparam logic [7:0] ADDR_MICRO    = 8'hFB;
    localparam logic [7:0] ADDR_MILLI_LO = 8'hFC;
    localparam logic [7:0] ADDR_MILLI_HI = 8'hFD;
    localparam logic [7:0] ADDR_TENTH    = 8'hFE;
    localparam logic [7:0] ADDR_DOG      = 8'hFF;

    // Reset values.
    localparam logic [6:0] RST_INTERVAL = 7'h7F;
    localparam logic [5:0] RST_MICRO    = 6'h03;
    localparam logic [7:0] RST_MILLI_LO = 8'h9F;
    localparam logic [7:0] RST_MILLI_HI = 8'h0F;
    localparam logic [7:0] RST_TENTH    = 8'h63;
    localparam logic [7:0] RST_DOG      = 8'h00;

    // Field positions and widths.
    localparam int WRT_BIT       = 7;
    localparam int ARM_BIT       = 7;
    localparam int DISARM_BIT    = 6;
    localparam int KICK_BIT      = 5;
    localparam int DOG_CNT_W     = 5;
    localparam int INTERVAL_W    = 7;
    localparam int MICRO_W       = 6;
    localparam int MILLI_W       = 16;
    localparam int TENTH_W       = 8;
    localparam int RESET_SEL_BIT = 3;
    localparam int DOG_PD_BIT    = 2;
    localparam int TIMER_PD_BIT  = 1;

    function automatic logic sfr_hit(input logic [7:0] addr,
                                     input logic [7:0] offset);
        return addr == offset;
    endfunction

endpackage

// ---- core/stw_prescale.sv ----
// Programmable divider producing a one-cycle tick every div+1 enables.
`timescale 1ns/100ps
`default_nettype none
module stw_prescale #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Control
    input  wire logic         run,
    input  wire logic         en,
    input  wire logic [W-1:0] div,
    // Result
    output logic              tick
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic         tick_ff;
    logic         nxt_tick;

    // A lowered divisor never strands the counter above it.
    always_comb
    begin
        nxt_cnt  = cnt_ff;
        nxt_tick = 1'b0;
        if (!run)
        begin
            nxt_cnt = '0;
        end
        else if (en)
        begin
            if (cnt_ff >= div)
            begin
                nxt_cnt  = '0;
                nxt_tick = 1'b1;
            end
            else
            begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    tick_due_a: assert property (
        (run && en && cnt_ff == div) |=> (tick_ff && cnt_ff == '0))
        else $error("Divider missed its terminal tick.");
    tick_gap_a: assert property (
        (tick_ff && run && div != '0) |-> !nxt_tick)
        else $error("Divider ticked early.");
endmodule // stw_prescale
`default_nettype wire

// ---- core/stw_top.sv ----
// System tick prescalers, interval counters and watchdog.
`timescale 1ns/100ps
`default_nettype none
module stw_top (
    // Clock and reset
    input  wire logic       CORE_CLK,
    input  wire logic       RST_N,
    // Special function register port
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic [7:0] SFR_WDATA,
    input  wire logic       SFR_WR,
    input  wire logic       SFR_RD,
    output logic      [7:0] SFR_RDATA,
    // Configuration registers held elsewhere in the device
    input  wire logic [7:0] HW_CONFIG_ZERO,
    input  wire logic [7:0] POWER_CTRL,
    // Time bases
    output logic            MICRO_TICK,
    output logic            MILLI_TICK,
    output logic            TENTH_TICK,
    // Events
    output logic            SHORT_IRQ,
    output logic            LONG_IRQ,
    output logic            DOG_IRQ,
    output logic            DOG_SYS_RESET,
    input  wire logic       DOG_IRQ_ACK
);
    logic                       rst_meta_ff;
    logic                       rst_n;
    logic                       timer_run;
    logic                       micro_tick;
    logic                       milli_tick;
    logic                       tenth_tick;
    logic [5:0]                 micro_ff;
    logic [5:0]                 nxt_micro;
    logic [7:0]                 milli_lo_ff;
    logic [7:0]                 nxt_milli_lo;
    logic [7:0]                 milli_hi_ff;
    logic [7:0]                 nxt_milli_hi;
    logic [7:0]                 tenth_ff;
    logic [7:0]                 nxt_tenth;
    logic [7:0]                 rdata_ff;
    logic [7:0]                 nxt_rdata;
    logic [7:0]                 dog_ctl_ff;
    logic [7:0]                 nxt_dog_ctl;
    logic                       dog_en_ff;
    logic                       nxt_dog_en;
    logic [stw_pkg::DOG_CNT_W:0] dog_cnt_ff;
    logic [stw_pkg::DOG_CNT_W:0] nxt_dog_cnt;
    logic [stw_pkg::DOG_CNT_W:0] dog_limit;
    logic                       dog_irq_ff;
    logic                       nxt_dog_irq;
    logic                       dog_rst_ff;
    logic                       nxt_dog_rst;
    logic                       dog_wr;
    logic                       arm_done;
    logic                       disarm_done;
    logic                       kick_done;
    logic                       dog_run;
    logic                       expire;
    logic                       reset_sel;

    stw_ivl_if long_bus ();
    stw_ivl_if short_bus ();

    // Release of reset is synchronised; assertion stays asynchronous.
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_meta_ff <= 1'b0;
            rst_n       <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n       <= rst_meta_ff;
        end
    end

    assign timer_run = !POWER_CTRL[stw_pkg::TIMER_PD_BIT];
    assign reset_sel = HW_CONFIG_ZERO[stw_pkg::RESET_SEL_BIT];

    stw_prescale #(.W(stw_pkg::MICRO_W)) u_micro (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .run   (timer_run),
        .en    (1'b1),
        .div   (micro_ff),
        .tick  (micro_tick)
    );

    stw_prescale #(.W(stw_pkg::MILLI_W)) u_milli (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .run   (timer_run),
        .en    (1'b1),
        .div   ({milli_hi_ff, milli_lo_ff}),
        .tick  (milli_tick)
    );

    stw_prescale #(.W(stw_pkg::TENTH_W)) u_tenth (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .run   (timer_run),
        .en    (milli_tick),
        .div   (tenth_ff),
        .tick  (tenth_tick)
    );

    stw_interval u_long (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .run   (timer_run),
        .tick  (tenth_tick),
        .bus   (long_bus.cnt)
    );

    stw_interval u_short (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .run   (timer_run),
        .tick  (milli_tick),
        .bus   (short_bus.cnt)
    );

    assign long_bus.wr     = SFR_WR && stw_pkg::sfr_hit(SFR_ADDR,
                                                      stw_pkg::ADDR_LONG);
    assign long_bus.rd     = SFR_RD && stw_pkg::sfr_hit(SFR_ADDR,
                                                      stw_pkg::ADDR_LONG);
    assign long_bus.wdata  = SFR_WDATA;
    assign short_bus.wr    = SFR_WR && stw_pkg::sfr_hit(SFR_ADDR,
                                                      stw_pkg::ADDR_SHORT);
    assign short_bus.rd    = SFR_RD && stw_pkg::sfr_hit(SFR_ADDR,
                                                      stw_pkg::ADDR_SHORT);
    assign short_bus.wdata = SFR_WDATA;

    // Divider registers and read data.
    always_comb
    begin
        nxt_micro    = micro_ff;
        nxt_milli_lo = milli_lo_ff;
        nxt_milli_hi = milli_hi_ff;
        nxt_tenth    = tenth_ff;
        nxt_rdata    = rdata_ff;
        if (SFR_WR)
        begin
            unique case (SFR_ADDR)
                stw_pkg::ADDR_MICRO:    nxt_micro    = SFR_WDATA[5:0];
                stw_pkg::ADDR_MILLI_LO: nxt_milli_lo = SFR_WDATA;
                stw_pkg::ADDR_MILLI_HI: nxt_milli_hi = SFR_WDATA;
                stw_pkg::ADDR_TENTH:    nxt_tenth    = SFR_WDATA;
                default:                nxt_micro    = micro_ff;
            endcase
        end
        if (SFR_RD)
        begin
            unique case (SFR_ADDR)
                stw_pkg::ADDR_LONG:     nxt_rdata = {1'b0, long_bus.reload};
                stw_pkg::ADDR_SHORT:    nxt_rdata = {1'b0, short_bus.reload};
                stw_pkg::ADDR_MICRO:    nxt_rdata = {2'b00, micro_ff};
                stw_pkg::ADDR_MILLI_LO: nxt_rdata = milli_lo_ff;
                stw_pkg::ADDR_MILLI_HI: nxt_rdata = milli_hi_ff;
                stw_pkg::ADDR_TENTH:    nxt_rdata = tenth_ff;
                stw_pkg::ADDR_DOG:      nxt_rdata = dog_ctl_ff;
                default:                nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            micro_ff    <= stw_pkg::RST_MICRO;
            milli_lo_ff <= stw_pkg::RST_MILLI_LO;
            milli_hi_ff <= stw_pkg::RST_MILLI_HI;
            tenth_ff    <= stw_pkg::RST_TENTH;
            rdata_ff    <= 8'h00;
        end
        else
        begin
            micro_ff    <= nxt_micro;
            milli_lo_ff <= nxt_milli_lo;
            milli_hi_ff <= nxt_milli_hi;
            tenth_ff    <= nxt_tenth;
            rdata_ff    <= nxt_rdata;
        end
    end

    // Watchdog. The control byte remembers the last write so that a one
    // followed by a zero in a later write can be recognised.
    assign dog_wr      = SFR_WR && stw_pkg::sfr_hit(SFR_ADDR,
                                                    stw_pkg::ADDR_DOG);
    assign arm_done    = dog_wr && dog_ctl_ff[stw_pkg::ARM_BIT]
                         && !SFR_WDATA[stw_pkg::ARM_BIT];
    assign disarm_done = dog_wr && dog_ctl_ff[stw_pkg::DISARM_BIT]
                         && !SFR_WDATA[stw_pkg::DISARM_BIT];
    assign kick_done   = dog_wr && dog_ctl_ff[stw_pkg::KICK_BIT]
                         && !SFR_WDATA[stw_pkg::KICK_BIT];
    assign dog_run     = dog_en_ff && !POWER_CTRL[stw_pkg::DOG_PD_BIT];
    assign dog_limit   = {1'b0, dog_ctl_ff[stw_pkg::DOG_CNT_W-1:0]} + 1'b1;
    // The kick lands anywhere inside a tenth period, so the first counted
    // tick is partial; this is the documented one-tick uncertainty.
    assign expire      = dog_run && tenth_tick && dog_cnt_ff == dog_limit;

    always_comb
    begin
        nxt_dog_ctl = dog_wr ? SFR_WDATA : dog_ctl_ff;
        nxt_dog_en  = dog_en_ff;
        if (arm_done)
        begin
            nxt_dog_en = 1'b1;
        end
        if (disarm_done)
        begin
            nxt_dog_en = 1'b0;
        end
        nxt_dog_cnt = dog_cnt_ff;
        if (kick_done || expire || !dog_en_ff)
        begin
            nxt_dog_cnt = '0;
        end
        else if (dog_run && tenth_tick)
        begin
            nxt_dog_cnt = dog_cnt_ff + 1'b1;
        end
        nxt_dog_rst = expire && reset_sel;
        nxt_dog_irq = (expire && !reset_sel)
                      || (dog_irq_ff && !DOG_IRQ_ACK);
    end

    always_ff @(posedge CORE_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dog_ctl_ff <= stw_pkg::RST_DOG;
            dog_en_ff  <= 1'b0;
            dog_cnt_ff <= '0;
            dog_irq_ff <= 1'b0;
            dog_rst_ff <= 1'b0;
        end
        else
        begin
            dog_ctl_ff <= nxt_dog_ctl;
            dog_en_ff  <= nxt_dog_en;
            dog_cnt_ff <= nxt_dog_cnt;
            dog_irq_ff <= nxt_dog_irq;
            dog_rst_ff <= nxt_dog_rst;
        end
    end

    assign SFR_RDATA     = rdata_ff;
    assign MICRO_TICK    = micro_tick;
    assign MILLI_TICK    = milli_tick;
    assign TENTH_TICK    = tenth_tick;
    assign SHORT_IRQ     = short_bus.flag;
    assign LONG_IRQ      = long_bus.flag;
    assign DOG_IRQ       = dog_irq_ff;
    assign DOG_SYS_RESET = dog_rst_ff;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!rst_n);

    sequence arm_seq_s;
        arm_done && !disarm_done;
    endsequence

    sequence expire_seq_s;
        dog_run && tenth_tick && dog_cnt_ff == dog_limit;
    endsequence

    dog_arm_a: assert property (
        arm_seq_s |=> dog_en_ff)
        else $error("Arm sequence did not enable the watchdog.");
    dog_arm_only_a: assert property (
        $rose(dog_en_ff) |-> $past(arm_done))
        else $error("Watchdog enabled without an arm sequence.");
    dog_disarm_a: assert property (
        disarm_done |=> !dog_en_ff)
        else $error("Disarm sequence did not stop the watchdog.");
    dog_kick_a: assert property (
        kick_done |=> dog_cnt_ff == '0)
        else $error("Kick did not restart the watchdog count.");
    dog_reset_a: assert property (
        (expire_seq_s and reset_sel) |=> (DOG_SYS_RESET && !DOG_IRQ))
        else $error("Expiry with reset select gave no reset.");
    dog_irq_a: assert property (
        (expire_seq_s and !reset_sel) |=> (DOG_IRQ && !DOG_SYS_RESET))
        else $error("Expiry without reset select gave no interrupt.");
    dog_halt_a: assert property (
        (POWER_CTRL[stw_pkg::DOG_PD_BIT] && dog_en_ff && !kick_done)
        |=> $stable(dog_cnt_ff))
        else $error("Watchdog counted while powered down.");
    wrt_zero_a: assert property (
        (long_bus.rd || short_bus.rd) |=> !SFR_RDATA[stw_pkg::WRT_BIT])
        else $error("Timing bit read back as one.");
    timer_halt_a: assert property (
        POWER_CTRL[stw_pkg::TIMER_PD_BIT] [*2] |-> !MILLI_TICK)
        else $error("Millisecond tick ran while powered down.");
endmodule // stw_top
`default_nettype wire

// ---- dv/stw_top_test.sv ----
// Self-checking bench for the system tick and watchdog block.
`timescale 1ns/100ps
`default_nettype none
module stw_top_test;
    logic       core_clk    = 1'b0;
    logic       rst_n       = 1'b0;
    logic [7:0] sfr_addr    = 8'h00;
    logic [7:0] sfr_wdata   = 8'h00;
    logic       sfr_wr      = 1'b0;
    logic       sfr_rd      = 1'b0;
    logic [7:0] sfr_rdata;
    logic [7:0] hw_cfg      = 8'h00;
    logic [7:0] pwr         = 8'h06;
    logic       dog_ack     = 1'b0;
    logic       micro_tick;
    logic       milli_tick;
    logic       tenth_tick;
    logic       short_irq;
    logic       long_irq;
    logic       dog_irq;
    logic       dog_rst;
    int         bad_count   = 0;
    int         check_count = 0;
    int         cyc         = 0;

    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    stw_top dut (
        .CORE_CLK       (core_clk),
        .RST_N          (rst_n),
        .SFR_ADDR       (sfr_addr),
        .SFR_WDATA      (sfr_wdata),
        .SFR_WR         (sfr_wr),
        .SFR_RD         (sfr_rd),
        .SFR_RDATA      (sfr_rdata),
        .HW_CONFIG_ZERO (hw_cfg),
        .POWER_CTRL     (pwr),
        .MICRO_TICK     (micro_tick),
        .MILLI_TICK     (milli_tick),
        .TENTH_TICK     (tenth_tick),
        .SHORT_IRQ      (short_irq),
        .LONG_IRQ       (long_irq),
        .DOG_IRQ        (dog_irq),
        .DOG_SYS_RESET  (dog_rst),
        .DOG_IRQ_ACK    (dog_ack)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic sig(input int w);
        case (w)
            0: return micro_tick;
            1: return milli_tick;
            2: return tenth_tick;
            3: return short_irq;
            4: return long_irq;
            5: return dog_irq;
            default: return dog_rst;
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        #1;
        chk({8'h00, sfr_rdata}, {8'h00, exp});
    endtask

    // The bound keeps a stuck output from hanging the run.
    task automatic wait_rise(input int w, output int t);
        logic prev;
        prev = sig(w);
        t = 0;
        repeat (3000)
        begin
            @(posedge core_clk);
            #1;
            if (sig(w) === 1'b1 && prev !== 1'b1)
            begin
                t = cyc;
                return;
            end
            prev = sig(w);
        end
        bad_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    endtask

    task automatic quiet(input int w, input int n);
        int hits = 0;
        repeat (n)
        begin
            @(posedge core_clk);
            #1;
            if (sig(w) === 1'b1)
                hits++;
        end
        chk(16'(hits), 16'h0000);
    endtask

    task automatic period(input int w, input int exp);
        int t0;
        int t1;
        wait_rise(w, t0);
        wait_rise(w, t1);
        chk(16'(t1 - t0), 16'(exp));
    endtask

    task automatic t_reset();
        logic [7:0] rv [7] = '{8'h7F, 8'h7F, 8'h03, 8'h9F, 8'h0F, 8'h63, 8'h00};
        for (int i = 0; i < 7; i++)
            rd(stw_pkg::ADDR_LONG + 8'(i), rv[i]);
        quiet(0, 40);
        quiet(1, 40);
        wr(8'hF8, 8'hFF);
        rd(8'hF8, 8'h00);
        rd(stw_pkg::ADDR_MILLI_LO, 8'h9F);
        $display("reset test done");
    endtask

    // Dividers are set while the timer is off so that no stale count
    // from the reset values leaks into the measured periods.
    task automatic t_ticks();
        wr(stw_pkg::ADDR_MICRO, 8'hC2);
        wr(stw_pkg::ADDR_MILLI_LO, 8'h03);
        wr(stw_pkg::ADDR_MILLI_HI, 8'h00);
        wr(stw_pkg::ADDR_TENTH, 8'h01);
        @(posedge core_clk);
        pwr <= 8'h00;
        rd(stw_pkg::ADDR_MICRO, 8'h02);
        period(0, 3);
        period(1, 4);
        period(2, 8);
        $display("tick test done");
    endtask

    task automatic ivl(input logic [7:0] a, input int w, input int unit);
        int tw;
        int t0;
        int t1;
        int t2;
        int t3;
        tw = cyc;
        wr(a, 8'h82);
        wait_rise(w, t0);
        chk(16'(t0 - tw <= 3 * unit + 3), 16'h0001);
        chk(16'(t0 - tw >= 2 * unit + 3), 16'h0001);
        rd(a, 8'h02);
        chk(16'(sig(w)), 16'h0000);
        wait_rise(w, t1);
        chk(16'(t1 - t0), 16'(3 * unit));
        wr(a, 8'h01);
        rd(a, 8'h01);
        wait_rise(w, t2);
        chk(16'(t2 - t1), 16'(3 * unit));
        rd(a, 8'h01);
        wait_rise(w, t3);
        chk(16'(t3 - t2), 16'(2 * unit));
        rd(a, 8'h01);
        $display("interval test done");
    endtask

    task automatic kick_and_expire(input int w);
        int tk;
        int te;
        wr(stw_pkg::ADDR_DOG, 8'h22);
        wr(stw_pkg::ADDR_DOG, 8'h02);
        tk = cyc;
        wait_rise(w, te);
        chk(16'(te - tk >= 24 && te - tk <= 34), 16'h0001);
    endtask

    task automatic t_dog();
        wr(stw_pkg::ADDR_DOG, 8'h02);
        wr(stw_pkg::ADDR_DOG, 8'h82);
        quiet(5, 60);
        wr(stw_pkg::ADDR_DOG, 8'h02);
        rd(stw_pkg::ADDR_DOG, 8'h02);
        kick_and_expire(5);
        chk(16'(dog_rst), 16'h0000);
        @(posedge core_clk);
        dog_ack <= 1'b1;
        @(posedge core_clk);
        dog_ack <= 1'b0;
        #1;
        chk(16'(dog_irq), 16'h0000);
        repeat (4)
        begin
            wr(stw_pkg::ADDR_DOG, 8'h22);
            wr(stw_pkg::ADDR_DOG, 8'h02);
            quiet(5, 12);
        end
        @(posedge core_clk);
        hw_cfg <= 8'h08;
        kick_and_expire(6);
        @(posedge core_clk);
        #1;
        chk(16'({dog_rst, dog_irq}), 16'h0000);
        wr(stw_pkg::ADDR_DOG, 8'h42);
        wr(stw_pkg::ADDR_DOG, 8'h02);
        quiet(6, 60);
        @(posedge core_clk);
        pwr <= 8'h04;
        wr(stw_pkg::ADDR_DOG, 8'h82);
        wr(stw_pkg::ADDR_DOG, 8'h02);
        quiet(6, 60);
        @(posedge core_clk);
        pwr <= 8'h00;
        kick_and_expire(6);
        $display("watchdog test done");
    endtask

    task automatic t_high_byte();
        wr(stw_pkg::ADDR_MILLI_LO, 8'h00);
        wr(stw_pkg::ADDR_MILLI_HI, 8'h01);
        period(1, 257);
        $display("high byte test done");
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_ticks();
        ivl(stw_pkg::ADDR_SHORT, 3, 4);
        ivl(stw_pkg::ADDR_LONG, 4, 8);
        t_dog();
        t_high_byte();
        end_of_test();
    end

    // The whole run needs well under ten thousand cycles.
    initial
    begin
        #400000;
        bad_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end_of_test();
    end
endmodule // stw_top_test
`default_nettype wire
